// File: design/hsb_slave.sv
// system bus slave port with a register bank for the hardened serial blocks
// Functional notes
// - all timing on one rising bus clock edge
// - strobe selects port, acknowledge answers it
// - direction low reads, high writes
// - full variant: 8-bit address and data
// - upper nibble picks instance, lower register
// - write takes at least three cycles
// - decode after strobe, optional wait states
// - write byte captured on terminating edge
// - acknowledge lasts one cycle, even while strobe stays high
// - read returns one byte, three cycles minimum
// - read data valid by acknowledge cycle
// - reduced variant ignores bus without chip select
// - reduced: 4-bit address, 10-bit fifo data
`timescale 1ns/10ps
module hsb_slave
  import hsb_pkg::*;
#(
  parameter bit REDUCED = 1'b0,
  parameter int WAIT_STATES = HSB_WAIT_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic transfer_strobe_in,
  input wire logic write_not_read_in,
  input wire logic [HSB_ADDR_W-1:0] register_address_in,
  input wire logic [HSB_DATA_W-1:0] write_byte_in,
  input wire logic [HSB_FIFO_DATA_W-1:0] write_word_in_reduced,
  input wire logic port_chip_select_in,
  input wire logic fifo_mode_in,
  input wire logic [HSB_SEL_HI-HSB_SEL_LO:0] instance_select_in,
  output logic [HSB_FIFO_DATA_W-1:0] read_byte_out,
  output logic transfer_ack_out
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  if (WAIT_STATES < 0 || WAIT_STATES > 255) begin : g_bad_wait
    $error("hsb_slave: wait states out of range");
  end

  // ************************************************************
  // request capture
  // ************************************************************
  hsb_req_t req;
  logic hit;
  logic [HSB_REG_HI:0] reg_index;

  always_comb begin
    req.strobe = transfer_strobe_in;
    req.write_not_read = write_not_read_in;
    req.address = register_address_in;
    req.wdata = {2'b00, write_byte_in};
    reg_index = register_address_in[HSB_REG_HI:HSB_REG_LO];
    hit = 1'b1;
    if (REDUCED) begin
      req.wdata = write_word_in_reduced;
      if (!fifo_mode_in) begin
        req.wdata = {2'b00, write_word_in_reduced[HSB_DATA_W-1:0]};
      end
      reg_index = register_address_in[HSB_RED_ADDR_W-1:0];
      hit = port_chip_select_in;
    end else begin
      hit = (register_address_in[HSB_SEL_HI:HSB_SEL_LO] == instance_select_in) &&
        ((instance_select_in == HSB_SEL_UPPER_LEFT) ||
         (instance_select_in == HSB_SEL_UPPER_RIGHT));
    end
  end

  // ************************************************************
  // transfer state machine
  // ************************************************************
  hsb_state_t state;
  hsb_state_t next_state;
  logic [7:0] wait_cnt;
  logic [7:0] next_wait_cnt;
  logic do_write;

  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    do_write = 1'b0;
    case (state)
      HSB_IDLE: begin
        if (req.strobe && hit) begin
          next_state = HSB_DECODE;
          next_wait_cnt = 8'(WAIT_STATES);
        end
      end
      HSB_DECODE: begin
        if (!req.strobe) begin
          next_state = HSB_IDLE;
        end else if (wait_cnt == 8'h00) begin
          next_state = HSB_ACK;
        end else begin
          next_wait_cnt = wait_cnt - 8'h01;
        end
      end
      HSB_ACK: begin
        do_write = req.write_not_read;
        next_state = req.strobe ? HSB_DONE : HSB_IDLE;
      end
      HSB_DONE: begin
        if (!req.strobe) begin
          next_state = HSB_IDLE;
        end
      end
      default: next_state = HSB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= HSB_IDLE;
      wait_cnt <= 8'h00;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  assign transfer_ack_out = (state == HSB_ACK);

  // ************************************************************
  // register bank and read data
  // ************************************************************
  logic [HSB_FIFO_DATA_W-1:0] regs [HSB_NUM_REGS];
  logic [HSB_FIFO_DATA_W-1:0] next_regs [HSB_NUM_REGS];
  logic [HSB_FIFO_DATA_W-1:0] rdata;
  logic [HSB_FIFO_DATA_W-1:0] next_rdata;

  always_comb begin
    for (int i = 0; i < HSB_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (do_write) begin
      next_regs[reg_index] = req.wdata;
    end
    next_rdata = rdata;
    if (state == HSB_DECODE && !req.write_not_read) begin
      next_rdata = regs[reg_index];
      if (!REDUCED || !fifo_mode_in) begin
        next_rdata = {2'b00, regs[reg_index][HSB_DATA_W-1:0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < HSB_NUM_REGS; i++) begin
        regs[i] <= HSB_REG_RESET;
      end
      rdata <= HSB_DATA_ZERO;
    end else begin
      for (int i = 0; i < HSB_NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      rdata <= next_rdata;
    end
  end

  assign read_byte_out = rdata;

  // ************************************************************
  // checks
  // ************************************************************
  property p_ack_needs_strobe;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(transfer_ack_out) |-> $past(transfer_strobe_in, 2) && $past(transfer_strobe_in);
  endproperty
  a_ack_needs_strobe: assert property (p_ack_needs_strobe) else $error("ack without strobe");

  property p_ack_one_cycle;
    @(posedge clk_in) disable iff (!rst_n_in)
      transfer_ack_out |=> !transfer_ack_out;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack held twice");

  logic acked;
  logic next_acked;

  always_comb begin
    next_acked = transfer_strobe_in && (transfer_ack_out || acked);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acked <= 1'b0;
    end else begin
      acked <= next_acked;
    end
  end

  property p_no_reack;
    @(posedge clk_in) disable iff (!rst_n_in)
      acked |-> !transfer_ack_out;
  endproperty
  a_no_reack: assert property (p_no_reack) else $error("second ack same strobe");

  property p_write_lands;
    @(posedge clk_in) disable iff (!rst_n_in)
      (transfer_ack_out && write_not_read_in) |=> regs[$past(reg_index)] == $past(req.wdata);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_read_valid;
    @(posedge clk_in) disable iff (!rst_n_in)
      (transfer_ack_out && !write_not_read_in && (REDUCED == 1'b0)) |->
        read_byte_out[HSB_DATA_W-1:0] == regs[reg_index][HSB_DATA_W-1:0];
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read data stale");

  property p_min_latency;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(transfer_strobe_in) && state == HSB_IDLE |=> !transfer_ack_out;
  endproperty
  a_min_latency: assert property (p_min_latency) else $error("ack too early");

  property p_ack_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state == HSB_IDLE && transfer_strobe_in && hit && WAIT_STATES == 0) ##1
        transfer_strobe_in |=> transfer_ack_out;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack late");

  property p_cs_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
      (REDUCED == 1'b1 && state == HSB_IDLE && !port_chip_select_in) |=> state == HSB_IDLE;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("selected without chip select");
endmodule

// File: shared/hsb_pkg.sv
// package of constants and carriers for the hardened-block system bus slave port
package hsb_pkg;
  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int HSB_ADDR_W = 8;
  localparam int HSB_DATA_W = 8;
  localparam int HSB_FIFO_DATA_W = 10;
  localparam int HSB_RED_ADDR_W = 4;
  localparam int HSB_SEL_HI = 7;
  localparam int HSB_SEL_LO = 4;
  localparam int HSB_REG_HI = 3;
  localparam int HSB_REG_LO = 0;
  localparam int HSB_NUM_REGS = 16;
  localparam logic [3:0] HSB_SEL_UPPER_LEFT = 4'h1;
  localparam logic [3:0] HSB_SEL_UPPER_RIGHT = 4'h3;
  localparam logic [9:0] HSB_REG_RESET = 10'h000;
  localparam logic [9:0] HSB_DATA_ZERO = 10'h000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int HSB_CLK_MAX_MHZ = 133;
  localparam int HSB_CLK_MHZ = 100;
  localparam int HSB_WAIT_DEFAULT = 0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic strobe;
    logic write_not_read;
    logic [HSB_ADDR_W-1:0] address;
    logic [HSB_FIFO_DATA_W-1:0] wdata;
  } hsb_req_t;

  typedef enum logic [1:0] {
    HSB_IDLE,
    HSB_DECODE,
    HSB_ACK,
    HSB_DONE
  } hsb_state_t;
endpackage

// File: verif/hsb_master_model.sv
// fabric-side bus master model for the slave port
`timescale 1ns/10ps
module hsb_master_model
  import hsb_pkg::*;
#(
  parameter int LIMIT = 40
) (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [HSB_FIFO_DATA_W-1:0] rdata_in,
  output hsb_req_t req_out
);
  initial req_out = '0;
  // ************************************************************
  // one transfer, bounded wait for acknowledge
  // ************************************************************
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [9:0] wd,
      input int hold, output int lat, output int extra, output logic [9:0] rd);
    lat = 0;
    extra = 0;
    @(negedge clk_in);
    req_out = {1'b1, wr, addr, wd};
    do begin
      @(negedge clk_in);
      lat++;
    end while (!ack_in && lat < LIMIT);
    // count the terminating edge
    if (ack_in) begin
      lat++;
    end
    rd = rdata_in;
    repeat (hold) begin
      @(negedge clk_in);
      extra += int'(ack_in);
    end
    @(negedge clk_in);
    req_out = {1'b0, 1'b0, ~addr, ~wd};
  endtask
endmodule

// File: verif/tb_hsb_slave.sv
// self-checking bench for full and reduced slave ports
`timescale 1ns/10ps
module tb_hsb_slave;
  import hsb_pkg::*;
  localparam int W_FULL = 2;
  localparam int ACK_LIMIT = 40;
  logic clk_in, rst_n_in, cs, fifo, ack_full, ack_red;
  logic [3:0] sel;
  logic [9:0] rd_full, rd_red;
  hsb_req_t req;
  int bad_count, checks;
  int mem[2][16];
  logic [31:0] seed;
  // ************************************************************
  // design instances and master
  // ************************************************************
  hsb_slave #(.REDUCED(1'b0), .WAIT_STATES(W_FULL)) hsb_slave_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .transfer_strobe_in(req.strobe),
    .write_not_read_in(req.write_not_read), .register_address_in(req.address),
    .write_byte_in(req.wdata[7:0]), .write_word_in_reduced(req.wdata),
    .port_chip_select_in(cs), .fifo_mode_in(fifo), .instance_select_in(sel),
    .read_byte_out(rd_full), .transfer_ack_out(ack_full));
  hsb_slave #(.REDUCED(1'b1), .WAIT_STATES(0)) hsb_slave_red_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .transfer_strobe_in(req.strobe),
    .write_not_read_in(req.write_not_read), .register_address_in(req.address),
    .write_byte_in(req.wdata[7:0]), .write_word_in_reduced(req.wdata),
    .port_chip_select_in(cs), .fifo_mode_in(fifo), .instance_select_in(sel),
    .read_byte_out(rd_red), .transfer_ack_out(ack_red));
  hsb_master_model #(.LIMIT(ACK_LIMIT)) hsb_master_model_inst (.clk_in(clk_in),
    .ack_in(ack_full | ack_red),
    .rdata_in(ack_full ? rd_full : rd_red), .req_out(req));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int lat, extra, red, rg;
    logic wr, stop;
    logic [7:0] addr;
    logic [9:0] wd, got;
    bad_count = 0;
    checks = 0;
    stop = 1'b0;
    seed = 32'hD0B5;
    rst_n_in = 1'b0;
    cs = 1'b0;
    fifo = 1'b0;
    sel = 4'h1;
    foreach (mem[a, b]) mem[a][b] = 0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int p = 0; p < 4 && !stop; p++) begin
      sel = (p == 1) ? 4'h3 : 4'h1;
      fifo = (p == 3);
      if (p == 3) begin
        rst_n_in = 1'b0;
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        foreach (mem[a, b]) mem[a][b] = 0;
      end
      red = (p >= 2);
      for (int i = 0; i < 12 && !stop; i++) begin
        seed = lfsr(seed);
        wr = seed[0] | (i == 0);
        rg = int'(seed[4:1]);
        wd = seed[14:5];
        addr = red ? {4'h0, seed[4:1]} : {(i == 0) ? sel ^ 4'h4 : sel, seed[4:1]};
        cs = red && i != 0;
        hsb_master_model_inst.xfer(wr, addr, wd, int'(seed[16:15]), lat, extra, got);
        check("latency", 10'(lat), (i == 0) ? 10'(ACK_LIMIT) : 10'(3 + (red ? 0 : W_FULL)));
        if (i != 0 && lat >= ACK_LIMIT) begin
          stop = 1'b1;
        end
        check("extra ack", 10'(extra), 10'h000);
        if (i != 0 && wr) begin
          mem[red][rg] = (red && fifo) ? int'(wd) : int'(wd[7:0]);
        end else if (i != 0) begin
          check("read data", got, 10'(mem[red][rg]));
        end
      end
    end
    end_of_test();
  end
endmodule
